// >>> inc/ipic_pkg.sv
// package: register map, field layout, reset values and timing for the input pin and irq control block
`default_nettype none
package ipic_pkg;

    // register offsets (8-bit register address space)
    localparam logic [7:0] ADDR_BIDIR_LEVEL  = 8'h2A;
    localparam logic [7:0] ADDR_PIN_FUNC     = 8'h2B;
    localparam logic [7:0] ADDR_PINS_LEVEL   = 8'h2F;
    localparam logic [7:0] ADDR_IRQ_CFG      = 8'h32;
    localparam logic [7:0] ADDR_IRQ_MASK     = 8'h33;
    localparam logic [7:0] ADDR_IRQ_LATCHED  = 8'h36;

    // reset values
    localparam logic [7:0] RST_PIN_FUNC      = 8'h00;
    localparam logic [7:0] RST_IRQ_CFG       = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK      = 8'hFF;

    // field positions
    localparam int POS_IN1_FUNC_LO           = 4;
    localparam int POS_BIAS_FUNC_LO          = 0;
    localparam int POS_IRQ_POL               = 7;
    localparam int POS_IRQ_STYLE_LO          = 5;
    localparam int POS_LATCH_VIEW            = 2;
    localparam int POS_LEVEL_HI              = 7;
    localparam int POS_LEVEL_LO              = 6;
    localparam int POS_SRC_LO                = 3;
    localparam int NUM_SRC                   = 5;

    // writable bit masks; reserved bits of the pin function and irq config registers read zero
    localparam logic [7:0] WMASK_PIN_FUNC    = 8'h77;
    localparam logic [7:0] WMASK_IRQ_CFG     = 8'hE4;

    // timing: 20 MHz clock
    localparam int CLK_HZ                    = 20_000_000;
    localparam int IRQ_PULSE_US              = 2000;
    localparam int IRQ_PERIOD_US             = 4000;
    localparam int PULSE_CYC                 = (IRQ_PULSE_US * (CLK_HZ / 1_000_000));
    localparam int PERIOD_CYC                = (IRQ_PERIOD_US * (CLK_HZ / 1_000_000));
    localparam int CNT_W                     = 17;

    // pin use encodings shared by both input pins
    typedef enum logic [2:0] {
        PIN_OFF      = 3'h0,
        PIN_GPI      = 3'h1,
        PIN_MCLK     = 3'h2,
        PIN_SER_IN   = 3'h3,
        PIN_PDM12    = 3'h4,
        PIN_PDM34    = 3'h5,
        PIN_RSVD     = 3'h6,
        PIN_ADC_PD   = 3'h7
    } ipic_pin_use_type;

    // interrupt assertion styles
    typedef enum logic [1:0] {
        STYLE_LEVEL  = 2'h0,
        STYLE_RSVD   = 2'h1,
        STYLE_REPEAT = 2'h2,
        STYLE_PULSE  = 2'h3
    } ipic_style_type;

    // register bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ipic_req_type;

    // routed input functions out of the pin muxes
    typedef struct packed {
        logic mclk;
        logic ser_in;
        logic pdm12;
        logic pdm34;
        logic adc_pd;
    } ipic_route_type;

    // pulse-style interrupt timer states, gray along idle->high->low
    typedef enum logic [1:0] {
        TMR_IDLE = 2'b00,
        TMR_HIGH = 2'b01,
        TMR_LOW  = 2'b11
    } ipic_tmr_type;

endpackage : ipic_pkg
`default_nettype wire

// >>> core/ipic_pin_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module ipic_pin_sync (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic pin_in,
    output var  logic level_ff
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    // shift chain, first stage feeds only the second
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // accept a change once stages two and three agree
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            level_ff <= 1'b0;
        end else if (s2_ff == s3_ff) begin
            level_ff <= s3_ff;
        end
    end
endmodule : ipic_pin_sync
`default_nettype wire

// >>> core/ipic_top.sv
// input pin function, level monitor and interrupt generation
//
// What this block does
// - bidir pin level reads at bit seven
// - pin1 field: disabled, general input, clock
// - codes 3,4,5 route serial/pdm; 6 reserved
// - code 7 powers down all ADC channels
// - bias pin field uses same encodings
// - monitor shows pin1 bit7, bias bit6
// - polarity bit: 0 active low, 1 high
// - style 0 holds irq while pending
// - style 2 asserts 2ms every 4ms
// - style 3 one 2ms pulse per event
// - view bit hides masked latched flags
// - mask bit7 gates clock error source
// - mask bit6 gates pll lock source
// - mask bit5 gates mixing saturation source
// - mask bits 4,3 gate activity sources
// - mask register resets to all ones
// - functions and irq config reset zero
// - latched flags bits 7..3, clear on read
// - irq reaches pin only when selected
`timescale 1ns/1ns
`default_nettype none
module ipic_top
    import ipic_pkg::*;
(
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire ipic_pkg::ipic_req_type   req,
    output var  logic [7:0]               rdata_ff,
    input  wire logic                     bidir_pin_in,
    input  wire logic                     bidir_is_gpi,
    input  wire logic                     analog_pos_in2_pin,
    input  wire logic                     mic_bias_pin,
    input  wire logic [NUM_SRC-1:0]       irq_events,
    input  wire logic                     irq_pin_selected,
    output var  logic                     irq_pin_out_ff,
    output var  logic                     irq_pin_oe_n_ff,
    output var  ipic_pkg::ipic_route_type route_ff
);
    import ipic_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers and internal state
    logic [7:0]         pin_func_ff;
    logic [7:0]         irq_cfg_ff;
    logic [7:0]         irq_mask_ff;
    logic [NUM_SRC-1:0] latched_ff;
    logic [NUM_SRC-1:0] evt_prev_ff;
    logic               bidir_lvl;
    logic               in1_lvl;
    logic               bias_lvl;
    ipic_pin_use_type   in1_use;
    ipic_pin_use_type   bias_use;
    ipic_style_type     style;
    logic [NUM_SRC-1:0] src_mask;
    logic [NUM_SRC-1:0] evt_rise;
    logic [NUM_SRC-1:0] latch_view;
    logic               pending;
    logic               new_event;
    logic               irq_active;
    ipic_tmr_type       tmr_ff;
    ipic_tmr_type       nxt_tmr;
    logic [CNT_W-1:0]   cnt_ff;
    logic [CNT_W-1:0]   nxt_cnt;
    logic [7:0]         nxt_rdata;
    ipic_route_type     nxt_route;

    // masked write merge
    function automatic logic [7:0] merge_wr(input logic [7:0] wd, input logic [7:0] wm);
        merge_wr = wd & wm;
    endfunction : merge_wr

    // true when a pin use field equals a code
    function automatic logic use_is(input ipic_pin_use_type u, input ipic_pin_use_type c);
        use_is = (u == c);
    endfunction : use_is

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    ipic_pin_sync u_sync_bidir (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .pin_in   (bidir_pin_in),
        .level_ff (bidir_lvl)
    );

    ipic_pin_sync u_sync_in1 (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .pin_in   (analog_pos_in2_pin),
        .level_ff (in1_lvl)
    );

    ipic_pin_sync u_sync_bias (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .pin_in   (mic_bias_pin),
        .level_ff (bias_lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    // field decode
    assign in1_use  = ipic_pin_use_type'(pin_func_ff[POS_IN1_FUNC_LO +: 3]);
    assign bias_use = ipic_pin_use_type'(pin_func_ff[POS_BIAS_FUNC_LO +: 3]);
    assign style    = ipic_style_type'(irq_cfg_ff[POS_IRQ_STYLE_LO +: 2]);
    assign src_mask = irq_mask_ff[POS_SRC_LO +: NUM_SRC];

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    // mask resets ones
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_mask_ff <= RST_IRQ_MASK;
        end else if (req.wr && req.addr == ADDR_IRQ_MASK) begin
            irq_mask_ff <= req.wdata;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_func_ff <= RST_PIN_FUNC;
        end else if (req.wr && req.addr == ADDR_PIN_FUNC) begin
            pin_func_ff <= merge_wr(req.wdata, WMASK_PIN_FUNC);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_cfg_ff <= RST_IRQ_CFG;
        end else if (req.wr && req.addr == ADDR_IRQ_CFG) begin
            irq_cfg_ff <= merge_wr(req.wdata, WMASK_IRQ_CFG);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin routing
    always_comb begin
        nxt_route.mclk   = (use_is(in1_use, PIN_MCLK) & in1_lvl) | (use_is(bias_use, PIN_MCLK) & bias_lvl);
        nxt_route.ser_in = (use_is(in1_use, PIN_SER_IN) & in1_lvl) | (use_is(bias_use, PIN_SER_IN) & bias_lvl);
        nxt_route.pdm12  = (use_is(in1_use, PIN_PDM12) & in1_lvl) | (use_is(bias_use, PIN_PDM12) & bias_lvl);
        nxt_route.pdm34  = (use_is(in1_use, PIN_PDM34) & in1_lvl) | (use_is(bias_use, PIN_PDM34) & bias_lvl);
        nxt_route.adc_pd = (use_is(in1_use, PIN_ADC_PD) & in1_lvl) | (use_is(bias_use, PIN_ADC_PD) & bias_lvl);
    end

    // registered route outputs
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            route_ff <= '0;
        end else begin
            route_ff <= nxt_route;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event capture and latched flags
    assign evt_rise = irq_events & ~evt_prev_ff;

    // edge detect of source events
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            evt_prev_ff <= '0;
        end else begin
            evt_prev_ff <= irq_events;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            latched_ff <= '0;
        end else if (req.rd && req.addr == ADDR_IRQ_LATCHED) begin
            latched_ff <= (latched_ff & ~latch_view) | evt_rise;
        end else begin
            latched_ff <= latched_ff | evt_rise;
        end
    end

    assign latch_view = irq_cfg_ff[POS_LATCH_VIEW] ? (latched_ff & ~src_mask) : latched_ff;

    assign pending   = |(latched_ff & ~src_mask);
    assign new_event = |(evt_rise & ~src_mask);

    ////////////////////////////////////////////////////////////////////////
    // register readback
    always_comb begin
        nxt_rdata = 8'h00;
        unique case (req.addr)
            ADDR_BIDIR_LEVEL: nxt_rdata[POS_LEVEL_HI] = bidir_lvl & bidir_is_gpi;
            ADDR_PIN_FUNC:    nxt_rdata = pin_func_ff;
            ADDR_PINS_LEVEL: begin
                nxt_rdata[POS_LEVEL_HI] = in1_lvl & use_is(in1_use, PIN_GPI);
                nxt_rdata[POS_LEVEL_LO] = bias_lvl & use_is(bias_use, PIN_GPI);
            end
            ADDR_IRQ_CFG:     nxt_rdata = irq_cfg_ff;
            ADDR_IRQ_MASK:    nxt_rdata = irq_mask_ff;
            ADDR_IRQ_LATCHED: nxt_rdata[POS_SRC_LO +: NUM_SRC] = latch_view;
            default:          nxt_rdata = 8'h00;
        endcase
    end

    // read data register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else if (req.rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timed interrupt styles
    always_comb begin
        nxt_tmr = tmr_ff;
        nxt_cnt = cnt_ff;
        unique case (tmr_ff)
            TMR_IDLE: begin
                if ((style == STYLE_REPEAT && pending) || (style == STYLE_PULSE && new_event)) begin
                    nxt_tmr = TMR_HIGH;
                    nxt_cnt = CNT_W'(PULSE_CYC - 1);
                end
            end
            TMR_HIGH: begin
                if (cnt_ff != '0) begin
                    nxt_cnt = cnt_ff - 1'b1;
                end else if (style == STYLE_REPEAT) begin
                    nxt_tmr = TMR_LOW;
                    nxt_cnt = CNT_W'(PERIOD_CYC - PULSE_CYC - 1);
                end else begin
                    nxt_tmr = TMR_IDLE;
                end
            end
            TMR_LOW: begin
                if (cnt_ff != '0) begin
                    nxt_cnt = cnt_ff - 1'b1;
                end else begin
                    nxt_tmr = TMR_IDLE;
                end
            end
            default: begin
                nxt_tmr = TMR_IDLE;
                nxt_cnt = '0;
            end
        endcase
    end

    // timer state and counter
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tmr_ff <= TMR_IDLE;
            cnt_ff <= '0;
        end else begin
            tmr_ff <= nxt_tmr;
            cnt_ff <= nxt_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt output
    always_comb begin
        unique case (style)
            STYLE_LEVEL:  irq_active = pending;
            STYLE_RSVD:   irq_active = pending;
            STYLE_REPEAT: irq_active = (tmr_ff == TMR_HIGH);
            STYLE_PULSE:  irq_active = (tmr_ff == TMR_HIGH);
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_pin_out_ff  <= 1'b1;
            irq_pin_oe_n_ff <= 1'b1;
        end else begin
            irq_pin_out_ff  <= irq_cfg_ff[POS_IRQ_POL] ? irq_active : ~irq_active;
            irq_pin_oe_n_ff <= ~irq_pin_selected;
        end
    end

endmodule : ipic_top
`default_nettype wire

// >>> tb/ipic_props.sv
// checker: port relations of the input pin and irq control block
`timescale 1ns/1ns
`default_nettype none
module ipic_props
    import ipic_pkg::*;
(
    input wire logic                     sys_clk,
    input wire logic                     rst,
    input wire ipic_pkg::ipic_req_type   req,
    input wire logic [7:0]               rdata_ff,
    input wire logic                     bidir_pin_in,
    input wire logic                     bidir_is_gpi,
    input wire logic                     analog_pos_in2_pin,
    input wire logic                     mic_bias_pin,
    input wire logic [NUM_SRC-1:0]       irq_events,
    input wire logic                     irq_pin_selected,
    input wire logic                     irq_pin_out_ff,
    input wire logic                     irq_pin_oe_n_ff,
    input wire ipic_pkg::ipic_route_type route_ff
);
    localparam int ACT_MAX = PULSE_CYC + 2;
    logic [7:0]       cfg_ff;
    logic [7:0]       mask_ff;
    logic [7:0]       fn_ff;
    logic [CNT_W-1:0] act_cnt_ff;
    logic             act;
    // irq active under the programmed polarity
    assign act = (irq_pin_out_ff == cfg_ff[7]);
    // shadow of the programmed registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_ff <= RST_IRQ_CFG;
            mask_ff <= RST_IRQ_MASK;
            fn_ff <= RST_PIN_FUNC;
        end else if (req.wr) begin
            if (req.addr == ADDR_IRQ_CFG)
                cfg_ff <= req.wdata & WMASK_IRQ_CFG;
            if (req.addr == ADDR_IRQ_MASK)
                mask_ff <= req.wdata;
            if (req.addr == ADDR_PIN_FUNC)
                fn_ff <= req.wdata & WMASK_PIN_FUNC;
        end
    end
    // length of the current active stretch
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst)
            act_cnt_ff <= '0;
        else
            act_cnt_ff <= act ? act_cnt_ff + 1'b1 : '0;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    property p_oe;
        1'b1 |=> irq_pin_oe_n_ff == !$past(irq_pin_selected);
    endproperty
    a_oe: assert property (p_oe) else $error("irq pin enable off selection");
    property p_bidir;
        req.rd && req.addr == ADDR_BIDIR_LEVEL |=> rdata_ff[6:0] == 7'h00;
    endproperty
    a_bidir: assert property (p_bidir) else $error("bidir level spare bits set");
    property p_latch;
        req.rd && req.addr == ADDR_IRQ_LATCHED |=> rdata_ff[2:0] == 3'h0;
    endproperty
    a_latch: assert property (p_latch) else $error("latched spare bits set");
    property p_cfg;
        req.rd && req.addr == ADDR_IRQ_CFG |=> rdata_ff == cfg_ff;
    endproperty
    a_cfg: assert property (p_cfg) else $error("irq config readback wrong");
    property p_mask;
        req.rd && req.addr == ADDR_IRQ_MASK |=> rdata_ff == mask_ff;
    endproperty
    a_mask: assert property (p_mask) else $error("mask readback wrong");
    property p_fn;
        req.rd && req.addr == ADDR_PIN_FUNC |=> rdata_ff == fn_ff;
    endproperty
    a_fn: assert property (p_fn) else $error("pin function readback wrong");
    property p_route;
        (fn_ff == 8'h00)[*3] |-> route_ff == '0;
    endproperty
    a_route: assert property (p_route) else $error("route active on disabled pins");
    property p_level;
        cfg_ff[6:5] == 2'h0 && !mask_ff[7] && $rose(irq_events[4]) |-> ##[1:3] act;
    endproperty
    a_level: assert property (p_level) else $error("level irq not raised");
    property p_act;
        cfg_ff[6] |-> act_cnt_ff <= ACT_MAX;
    endproperty
    a_act: assert property (p_act) else $error("irq active too long");
    property p_pulse;
        cfg_ff[6:5] == 2'h3 && $rose(act) |=> act[*8];
    endproperty
    a_pulse: assert property (p_pulse) else $error("irq pulse cut short");
    property p_hold;
        !req.rd |=> $stable(rdata_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
endmodule : ipic_props
bind ipic_top ipic_props ipic_props_i (.sys_clk, .rst, .req, .rdata_ff, .bidir_pin_in, .bidir_is_gpi,
    .analog_pos_in2_pin, .mic_bias_pin, .irq_events, .irq_pin_selected, .irq_pin_out_ff,
    .irq_pin_oe_n_ff, .route_ff);
`default_nettype wire

// >>> tb/ipic_host_model.sv
// host model: register writes and reads toward the block
`timescale 1ns/1ns
`default_nettype none
module ipic_host_model
    import ipic_pkg::*;
(
    input  wire logic                   sys_clk,
    output var  ipic_pkg::ipic_req_type req,
    input  wire logic [7:0]             rdata_ff
);
    initial req = '0;
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == ADDR_PIN_FUNC)
            v = d & WMASK_PIN_FUNC;
        if (a == ADDR_IRQ_CFG)
            v = d & WMASK_IRQ_CFG;
        if (a == ADDR_IRQ_MASK)
            v = d | 8'h07;
        @(negedge sys_clk);
        req = {1'b1, 1'b0, a, v};
        @(negedge sys_clk);
        req = '0;
    endtask : wr
    // one read strobe, data taken a cycle later
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        req = {1'b0, 1'b1, a, 8'h00};
        @(negedge sys_clk);
        req = '0;
        d = rdata_ff;
    endtask : rd
endmodule : ipic_host_model
`default_nettype wire

// >>> tb/tb_ipic_top.sv
// self-checking bench for the input pin and irq control block
`timescale 1ns/1ns
`default_nettype none
module tb_ipic_top;
    import ipic_pkg::*;
    logic               sys_clk = 1'b0;
    logic               rst = 1'b1;
    ipic_req_type       req;
    logic [7:0]         rdata_ff;
    logic               bidir_pin_in = 1'b0;
    logic               bidir_is_gpi = 1'b0;
    logic               analog_pos_in2_pin = 1'b0;
    logic               mic_bias_pin = 1'b0;
    logic [NUM_SRC-1:0] irq_events = '0;
    logic               irq_pin_selected = 1'b0;
    logic               irq_pin_out_ff;
    logic               irq_pin_oe_n_ff;
    ipic_route_type     route_ff;
    int                 errors = 0;
    int                 n_checks = 0;
    int                 cycles = 0;
    always #25 sys_clk = ~sys_clk;
    ipic_top ipic_top_i (.sys_clk, .rst, .req, .rdata_ff, .bidir_pin_in, .bidir_is_gpi, .analog_pos_in2_pin,
        .mic_bias_pin, .irq_events, .irq_pin_selected, .irq_pin_out_ff, .irq_pin_oe_n_ff, .route_ff);
    ipic_host_model ipic_host_model_i (.sys_clk, .req, .rdata_ff);
    ////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task report_and_stop;
        if (errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    // cycle ceiling against hangs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 90000) begin
            errors++;
            report_and_stop();
        end
    end
    task cmp(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task irq_is(input logic e);
        cmp({7'h0, irq_pin_out_ff}, {7'h0, e});
    endtask : irq_is
    task step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : step
    task wr(input logic [7:0] a, input logic [7:0] d);
        ipic_host_model_i.wr(a, d);
    endtask : wr
    task rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        ipic_host_model_i.rd(a, v);
        cmp(v, exp);
    endtask : rchk
    task pulse_ev(input int i);
        irq_events[i] = 1'b1;
        step(2);
        irq_events[i] = 1'b0;
        step(4);
    endtask : pulse_ev
    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        rchk(ADDR_PIN_FUNC, RST_PIN_FUNC);
        rchk(ADDR_IRQ_CFG, RST_IRQ_CFG);
        rchk(ADDR_IRQ_MASK, RST_IRQ_MASK);
        rchk(8'h40, 8'h00);
        irq_is(1'b1);
        cmp({7'h0, irq_pin_oe_n_ff}, 8'h01);
        irq_pin_selected = 1'b1;
        step(2);
        cmp({7'h0, irq_pin_oe_n_ff}, 8'h00);
        irq_pin_selected = 1'b0;
    endtask : t_reset
    task t_pins;
        bidir_pin_in = 1'b1;
        analog_pos_in2_pin = 1'b1;
        mic_bias_pin = 1'b1;
        step(8);
        rchk(ADDR_BIDIR_LEVEL, 8'h00);
        rchk(ADDR_PINS_LEVEL, 8'h00);
        bidir_is_gpi = 1'b1;
        wr(ADDR_PIN_FUNC, 8'h11);
        step(8);
        rchk(ADDR_BIDIR_LEVEL, 8'h80);
        rchk(ADDR_PINS_LEVEL, 8'hC0);
        mic_bias_pin = 1'b0;
        step(8);
        rchk(ADDR_PINS_LEVEL, 8'h80);
        mic_bias_pin = 1'b1;
    endtask : t_pins
    task t_route;
        for (int p = 0; p < 2; p++) begin
            for (int c = 2; c < 8; c++) begin
                if (c == 6)
                    continue;
                wr(ADDR_PIN_FUNC, p ? 8'(c) : 8'(c << 4));
                step(8);
                cmp({3'h0, route_ff}, 8'h01 << ((c == 7) ? 0 : 6 - c));
            end
        end
        // routed power-down input must follow the bias pin level
        mic_bias_pin = 1'b0;
        step(8);
        cmp({3'h0, route_ff}, 8'h00);
        mic_bias_pin = 1'b1;
        wr(ADDR_PIN_FUNC, 8'h00);
    endtask : t_route
    task t_view;
        wr(ADDR_IRQ_MASK, 8'h7F);
        wr(ADDR_IRQ_CFG, 8'h04);
        pulse_ev(4);
        pulse_ev(0);
        irq_is(1'b0);
        rchk(ADDR_IRQ_LATCHED, 8'h80);
        step(3);
        irq_is(1'b1);
        wr(ADDR_IRQ_CFG, 8'h00);
        rchk(ADDR_IRQ_LATCHED, 8'h08);
        rchk(ADDR_IRQ_LATCHED, 8'h00);
    endtask : t_view
    task t_sources;
        wr(ADDR_IRQ_CFG, 8'h80);
        for (int i = 0; i < NUM_SRC; i++) begin
            wr(ADDR_IRQ_MASK, 8'hFF ^ (8'h08 << i));
            pulse_ev((i + 1) % NUM_SRC);
            step(3);
            irq_is(1'b0);
            pulse_ev(i);
            irq_is(1'b1);
            rchk(ADDR_IRQ_LATCHED, (8'h08 << i) | (8'h08 << ((i + 1) % NUM_SRC)));
            step(3);
            irq_is(1'b0);
        end
    endtask : t_sources
    task t_styles;
        wr(ADDR_IRQ_MASK, 8'h7F);
        wr(ADDR_IRQ_CFG, 8'hE0);
        pulse_ev(4);
        irq_is(1'b1);
        step(PULSE_CYC - 20);
        irq_is(1'b1);
        step(30);
        irq_is(1'b0);
        rchk(ADDR_IRQ_LATCHED, 8'h80);
        wr(ADDR_IRQ_CFG, 8'hC0);
        pulse_ev(4);
        irq_is(1'b1);
        step(PULSE_CYC - 20);
        irq_is(1'b1);
        step(30);
        irq_is(1'b0);
        rchk(ADDR_IRQ_LATCHED, 8'h80);
    endtask : t_styles
    // reset, then the scenarios in turn
    initial begin
        step(8);
        rst = 1'b0;
        step(1);
        t_reset();
        t_pins();
        t_route();
        t_view();
        t_sources();
        t_styles();
        report_and_stop();
    end
endmodule : tb_ipic_top
`default_nettype wire
